/* flc_consts.svh */
// Constants of the flash program/erase controller: offsets, codes, resets, times.
// Assumes inclusion by bare name from the sector lock and controller modules.
`ifndef FLC_CONSTS_SVH
`define FLC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define FLC_IDX_CMD 12'hFF8
`define FLC_IDX_PAGE 12'hFF9
`define FLC_IDX_KHZH 12'hFFA
`define FLC_IDX_KHZL 12'hFFB

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define FLC_CMD_LOCK 8'h00
`define FLC_CMD_KEY1 8'h73
`define FLC_CMD_KEY2 8'h8C
`define FLC_CMD_PERASE 8'h95
`define FLC_CMD_MERASE 8'h63
`define FLC_CMD_PROTSEL 8'h5E

// ----------------------------------------------------------------------
// Status codes, reset value and erased value
// ----------------------------------------------------------------------
`define FLC_ST_LOCKED 6'h00
`define FLC_ST_KEY1 6'h01
`define FLC_ST_KEY2 6'h02
`define FLC_ST_OPEN 6'h03
`define FLC_ST_PROT 6'h04
`define FLC_ST_PROG 6'h08
`define FLC_ST_PERASE 6'h10
`define FLC_ST_MERASE 6'h20
`define FLC_RST_BYTE 8'h00
`define FLC_ERASED 8'hFF

// ----------------------------------------------------------------------
// Operation times in microseconds (cycles come from the kHz register), page and sector address bits
// ----------------------------------------------------------------------
`define FLC_PROG_US 40
`define FLC_PERASE_US 10000
`define FLC_MERASE_US 200000
`define FLC_PAGE_LSB 9
`define FLC_SECT_LSB 11

`endif

/* flc_pkg.sv */
// Types shared by the flash program/erase controller modules.
// Assumes flc_consts.svh is on the include path.
package flc_pkg;
  // Controller states
  typedef enum logic [2:0] {
    FLC_LOCKED = 3'b000,
    FLC_KEY1 = 3'b001,
    FLC_KEY2 = 3'b010,
    FLC_OPEN = 3'b011,
    FLC_PROT = 3'b100,
    FLC_PROG = 3'b101,
    FLC_PERASE = 3'b110,
    FLC_MERASE = 3'b111
  } flc_state_e;

  // Operation sent to the array
  typedef enum logic [1:0] {
    FLC_OP_NONE = 2'b00,
    FLC_OP_PROG = 2'b01,
    FLC_OP_PERASE = 2'b10,
    FLC_OP_MERASE = 2'b11
  } flc_op_e;

  // Program-memory write from the core or debugger
  typedef struct packed {
    logic vld;
    logic dbg;
    logic [15:0] addr;
    logic [7:0] data;
  } flc_mem_wr_s;

  // Command to the flash array
  typedef struct packed {
    logic start;
    flc_op_e op;
    logic [15:0] addr;
    logic [7:0] clr_mask;
  } flc_flash_cmd_s;
endpackage

/* flc_op_timer.sv */
// Duration counter for one program or erase operation.
// Assumes a single clock and a one-cycle start pulse while idle.
`timescale 1ns/1ns
`default_nettype none
module flc_op_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [31:0] cycles,
  output logic done
);
  logic [31:0] cnt_r;
  logic busy_r;

  // ----------------------------------------------------------------------
  // Countdown; a zero length still lasts one cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 32'h0000_0000;
      busy_r <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= busy_r && (cnt_r <= 32'h0000_0001);
      if (start) begin
        cnt_r <= (cycles == 32'h0000_0000) ? 32'h0000_0001 : cycles;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 32'h0000_0001;
        busy_r <= (cnt_r > 32'h0000_0001);
      end
    end
  end
endmodule // flc_op_timer
`default_nettype wire

/* flc_sector_lock.sv */
// Sector guard register: core writes only set bits, debugger writes freely.
// Assumes wr is a one-cycle write strobe with data in wdata.
`timescale 1ns/1ns
`default_nettype none
`include "flc_consts.svh"
module flc_sector_lock (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr,
  input wire logic dbg,
  input wire logic [7:0] wdata,
  output logic [7:0] sector_guard_bit
);
  // ----------------------------------------------------------------------
  // Guard bits, cleared by every reset
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sector_guard_bit <= `FLC_RST_BYTE;
    end else if (wr) begin
      sector_guard_bit <= dbg ? wdata : (sector_guard_bit | wdata);
    end
  end

  // Core writes never clear a guard bit
  lock_set_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && !dbg) |=> ((sector_guard_bit & $past(sector_guard_bit)) == $past(sector_guard_bit)))
    else $error("core write cleared a sector guard bit");
endmodule // flc_sector_lock
`default_nettype wire

/* flc_controller.sv */
// Flash program/erase controller with APB register access.
// Assumes a synchronous core write port, an external array that ANDs the
// clear mask in, and option bits that are stable after reset.
`timescale 1ns/1ns
`default_nettype none
`include "flc_consts.svh"

// Operation
// - Core programs only inside the unlocked page
// - Erase gives all ones; programming clears bits
// - Core stalled during programming, interrupts deferred
// - Command zero locks the controller
// - No core programming in guarded sectors
// - Unlock needs zero, page, keys, same page
// - Page erase sets the selected page
// - Erase stalls core, then relocks
// - No erase of guarded-sector pages
// - Mass erase only from the debugger
// - Debugger ignores write option and guards
// - Debugger: any page, short unlock, page writable
// - Debugger may mass erase and clear guards
// - Read-protect option blocks debugger program/erase
// - Command write-only, status read-only, shared address
// - Unknown or misplaced commands lock
// - Guard select code redirects page address
// - Status encodes state, upper bits zero
// - Page field is address 15:9, info map bit
// - Guard bits set-only from core, reset zero
// - Page select readable, writable, resets zero
// - Reset leaves the controller locked
// - Any command write deselects the guard register
// - Write-protect option blocks core program/erase
// - Durations scale from the kHz value
module flc_controller
  import flc_pkg::*;
#(
  parameter int PROG_US = `FLC_PROG_US,
  parameter int PERASE_US = `FLC_PERASE_US,
  parameter int MERASE_US = `FLC_MERASE_US
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dbg_access,
  input wire logic opt_write_protect,
  input wire logic opt_read_protect,
  input wire flc_mem_wr_s mem_wr,
  output flc_flash_cmd_s flash_cmd,
  output logic cpu_stall,
  output logic irq_defer,
  output logic info_area_map_enable
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  flc_state_e state_r; // Controller state
  flc_state_e state_nxt;
  logic [7:0] page_select_reg; // Info map bit and page field
  logic page_seen_r; // Page written while locked
  logic page_seen_nxt;
  logic [15:0] clock_khz_value; // System clock in kHz
  logic [7:0] guard; // Sector guard bits
  logic op_done; // Operation time elapsed
  logic [5:0] state_code; // Status field

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  wire apb_fire = psel & penable & pready;
  wire apb_wr = apb_fire & pwrite;
  wire in_range = (paddr[15:14] == 2'b00) && (paddr[1:0] == 2'b00);
  wire [11:0] idx = paddr[13:2];
  wire sel_cmd = in_range && (idx == `FLC_IDX_CMD);
  wire sel_page = in_range && (idx == `FLC_IDX_PAGE);
  wire sel_khzh = in_range && (idx == `FLC_IDX_KHZH);
  wire sel_khzl = in_range && (idx == `FLC_IDX_KHZL);
  wire mapped = sel_cmd | sel_page | sel_khzh | sel_khzl;
  wire [7:0] wbyte = pwdata[7:0];
  wire busy = (state_r == FLC_PROG) | (state_r == FLC_PERASE) | (state_r == FLC_MERASE);
  wire prot_sel = (state_r == FLC_PROT);
  wire cmd_wr = apb_wr & sel_cmd & ~busy;
  wire page_wr = apb_wr & sel_page & ~prot_sel & ~busy;
  wire lock_wr = apb_wr & sel_page & prot_sel;

  // ----------------------------------------------------------------------
  // Permission checks
  // ----------------------------------------------------------------------
  wire [15:0] page_base = {page_select_reg[6:0], 9'h000};
  wire [2:0] page_sect = page_base[`FLC_SECT_LSB+2:`FLC_SECT_LSB];
  wire [2:0] wr_sect = mem_wr.addr[`FLC_SECT_LSB+2:`FLC_SECT_LSB];
  wire in_page = (mem_wr.addr[15:`FLC_PAGE_LSB] == page_select_reg[6:0]);
  wire cpu_prog_ok = ~opt_write_protect & ~guard[wr_sect] & in_page;
  wire dbg_prog_ok = ~opt_read_protect;
  wire prog_ok = mem_wr.dbg ? dbg_prog_ok : cpu_prog_ok;
  wire go_prog = (state_r == FLC_OPEN) & mem_wr.vld & prog_ok;
  wire erase_ok = dbg_access ? ~opt_read_protect
                             : (~opt_write_protect & ~guard[page_sect]);
  wire go_perase = (state_nxt == FLC_PERASE) & (state_r == FLC_OPEN);
  wire go_merase = (state_nxt == FLC_MERASE) & (state_r == FLC_OPEN);

  // ----------------------------------------------------------------------
  // Durations in cycles, rounded up from microseconds
  // ----------------------------------------------------------------------
  wire [39:0] khz_w = {24'h00_0000, clock_khz_value};
  wire [39:0] prog_cyc = (khz_w * 40'(PROG_US) + 40'd999) / 40'd1000;
  wire [39:0] perase_cyc = (khz_w * 40'(PERASE_US) + 40'd999) / 40'd1000;
  wire [39:0] merase_cyc = (khz_w * 40'(MERASE_US) + 40'd999) / 40'd1000;
  wire [39:0] dur_sel = go_prog ? prog_cyc : (go_perase ? perase_cyc : merase_cyc);
  wire op_start = go_prog | go_perase | go_merase;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    page_seen_nxt = page_seen_r;
    if (cmd_wr) begin
      // Any command write ends the previous step
      page_seen_nxt = 1'b0;
    end else if (page_wr && state_r == FLC_LOCKED) begin
      page_seen_nxt = 1'b1;
    end
    case (state_r)
      FLC_LOCKED: begin
        if (cmd_wr && wbyte == `FLC_CMD_KEY1 && page_seen_r) begin
          state_nxt = FLC_KEY1;
        end else if (cmd_wr && wbyte == `FLC_CMD_PROTSEL) begin
          state_nxt = FLC_PROT;
        end
      end
      FLC_KEY1: begin
        if (cmd_wr) begin
          // Debugger skips the page rewrite
          state_nxt = (wbyte != `FLC_CMD_KEY2) ? FLC_LOCKED
                    : (dbg_access ? FLC_OPEN : FLC_KEY2);
        end else if (page_wr) begin
          state_nxt = FLC_LOCKED;
        end
      end
      FLC_KEY2: begin
        if (cmd_wr) begin
          state_nxt = FLC_LOCKED;
        end else if (page_wr) begin
          state_nxt = (wbyte == page_select_reg) ? FLC_OPEN : FLC_LOCKED;
        end
      end
      FLC_OPEN: begin
        if (go_prog) begin
          state_nxt = FLC_PROG;
        end else if (cmd_wr) begin
          if (wbyte == `FLC_CMD_PERASE && erase_ok) begin
            state_nxt = FLC_PERASE;
          end else if (wbyte == `FLC_CMD_MERASE && dbg_access && ~opt_read_protect) begin
            state_nxt = FLC_MERASE;
          end else begin
            state_nxt = FLC_LOCKED;
          end
        end else if (page_wr && !dbg_access) begin
          state_nxt = FLC_LOCKED;
        end
      end
      FLC_PROT: begin
        if (cmd_wr) begin
          state_nxt = FLC_LOCKED;
        end
      end
      FLC_PROG: begin
        if (op_done) begin
          state_nxt = FLC_OPEN;
        end
      end
      FLC_PERASE, FLC_MERASE: begin
        if (op_done) begin
          state_nxt = FLC_LOCKED;
        end
      end
      default: begin
        state_nxt = FLC_LOCKED;
      end
    endcase
  end

  // Status field for each state
  always_comb begin
    case (state_r)
      FLC_LOCKED: state_code = `FLC_ST_LOCKED;
      FLC_KEY1: state_code = `FLC_ST_KEY1;
      FLC_KEY2: state_code = `FLC_ST_KEY2;
      FLC_OPEN: state_code = `FLC_ST_OPEN;
      FLC_PROT: state_code = `FLC_ST_PROT;
      FLC_PROG: state_code = `FLC_ST_PROG;
      FLC_PERASE: state_code = `FLC_ST_PERASE;
      FLC_MERASE: state_code = `FLC_ST_MERASE;
      default: state_code = `FLC_ST_LOCKED;
    endcase
  end

  // Read mux; command address reads status
  wire [7:0] rd_byte = sel_cmd ? {2'b00, state_code}
                     : sel_page ? (prot_sel ? guard : page_select_reg)
                     : sel_khzh ? clock_khz_value[15:8]
                     : sel_khzl ? clock_khz_value[7:0] : `FLC_RST_BYTE;

  // ----------------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= FLC_LOCKED;
      page_seen_r <= 1'b0;
      page_select_reg <= `FLC_RST_BYTE;
      clock_khz_value <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      page_seen_r <= page_seen_nxt;
      if (page_wr) begin
        page_select_reg <= wbyte;
      end
      if (apb_wr && sel_khzh) begin
        clock_khz_value[15:8] <= wbyte;
      end
      if (apb_wr && sel_khzl) begin
        clock_khz_value[7:0] <= wbyte;
      end
    end
  end

  // APB answer one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= (psel & ~penable & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Array command, stall and map outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_cmd <= '0;
      cpu_stall <= 1'b0;
      irq_defer <= 1'b0;
      info_area_map_enable <= 1'b0;
    end else begin
      flash_cmd.start <= op_start;
      flash_cmd.op <= go_prog ? FLC_OP_PROG : (go_perase ? FLC_OP_PERASE
                   : (go_merase ? FLC_OP_MERASE : FLC_OP_NONE));
      flash_cmd.addr <= go_prog ? mem_wr.addr : page_base;
      flash_cmd.clr_mask <= go_prog ? ~mem_wr.data : ~`FLC_ERASED;
      cpu_stall <= (state_nxt == FLC_PROG) | (state_nxt == FLC_PERASE)
                 | (state_nxt == FLC_MERASE);
      irq_defer <= (state_nxt == FLC_PROG) | (state_nxt == FLC_PERASE)
                 | (state_nxt == FLC_MERASE);
      info_area_map_enable <= page_select_reg[7];
    end
  end

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  flc_op_timer u_timer (
    .clk(pclk),
    .rst_n(presetn),
    .start(op_start),
    .cycles(dur_sel[31:0]),
    .done(op_done)
  );

  flc_sector_lock u_guard (
    .clk(pclk),
    .rst_n(presetn),
    .wr(lock_wr),
    .dbg(dbg_access),
    .wdata(wbyte),
    .sector_guard_bit(guard)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  off_page_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == FLC_OPEN && mem_wr.vld && !mem_wr.dbg && !in_page) |=> !flash_cmd.start)
    else $error("core write outside the page started programming");
  clear_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    go_prog |=> (flash_cmd.op == FLC_OP_PROG && flash_cmd.clr_mask == ~$past(mem_wr.data)))
    else $error("program mask does not match written byte");
  prog_stall_a: assert property (@(posedge pclk) disable iff (!presetn)
    go_prog |=> cpu_stall && irq_defer)
    else $error("core not stalled during programming");
  zero_locks_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_wr && wbyte == `FLC_CMD_LOCK) |=> state_r == FLC_LOCKED)
    else $error("command zero did not lock");
  guarded_prog_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mem_wr.vld && !mem_wr.dbg && guard[wr_sect]) |=> !flash_cmd.start)
    else $error("guarded sector programmed by core");
  unlock_order_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == FLC_KEY2 && page_wr && wbyte == page_select_reg) |=> state_r == FLC_OPEN)
    else $error("matching page rewrite did not unlock");
  erase_relock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == FLC_PERASE && op_done) |=> (state_r == FLC_LOCKED && !cpu_stall))
    else $error("controller not relocked after erase");
  core_no_mass_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_wr && !dbg_access) |=> state_r != FLC_MERASE)
    else $error("core started a mass erase");
  bad_cmd_locks_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_wr && state_r == FLC_KEY2) |=> state_r == FLC_LOCKED)
    else $error("misplaced command did not lock");
  status_top_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && sel_cmd && !pwrite) |-> prdata[7:6] == 2'b00)
    else $error("status upper bits not zero");
  wp_blocks_a: assert property (@(posedge pclk) disable iff (!presetn)
    (opt_write_protect && !mem_wr.dbg && !dbg_access) |=> !flash_cmd.start)
    else $error("write protect option ignored for core");
  rp_blocks_a: assert property (@(posedge pclk) disable iff (!presetn)
    (opt_read_protect && mem_wr.dbg && dbg_access) |=> !flash_cmd.start)
    else $error("read protect option ignored for debugger");
  guard_desel_a: assert property (@(posedge pclk) disable iff (!presetn)
    (prot_sel && cmd_wr) |=> state_r == FLC_LOCKED)
    else $error("guard register stayed selected");
  perase_page_a: assert property (@(posedge pclk) disable iff (!presetn)
    go_perase |=> (flash_cmd.op == FLC_OP_PERASE && flash_cmd.addr == $past(page_base)))
    else $error("page erase sent to the wrong page");
  guarded_erase_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == FLC_OPEN && cmd_wr && !dbg_access && !mem_wr.vld && guard[page_sect])
    |=> !flash_cmd.start)
    else $error("guarded page erased by core");
  dbg_mass_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == FLC_OPEN && cmd_wr && dbg_access && !opt_read_protect && !mem_wr.vld
     && wbyte == `FLC_CMD_MERASE) |=> state_r == FLC_MERASE)
    else $error("debugger mass erase refused");
endmodule // flc_controller
`default_nettype wire

/* flc_flash_model.sv */
// Flash array model facing the controller's array command port.
// Assumes one start pulse per operation, sampled on the rising pclk edge.
`timescale 1ns/1ns
`default_nettype none
module flc_flash_model
  import flc_pkg::*;
(
  input wire logic pclk,
  input wire flc_flash_cmd_s flash_cmd,
  input wire logic [15:0] rd_addr,
  output logic [7:0] rd_data
);
  // ----------------------------------------
  // Storage and peek port
  // ----------------------------------------
  logic [7:0] mem [0:65535]; // Whole program space
  assign rd_data = mem[rd_addr]; // Bench looks at cells here

  // Array leaves the factory erased
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'hFF;
    end
  end

  // Apply each operation on its start pulse
  always @(posedge pclk) begin
    if (flash_cmd.start === 1'b1) begin
      case (flash_cmd.op)
        FLC_OP_PROG: begin // Only clears bits
          mem[flash_cmd.addr] <= mem[flash_cmd.addr] & ~flash_cmd.clr_mask;
        end
        FLC_OP_PERASE: begin // Whole 512-byte page to ones
          for (int i = 0; i < 512; i++) begin
            mem[{flash_cmd.addr[15:9], 9'h000} + i] <= 8'hFF;
          end
        end
        FLC_OP_MERASE: begin // Everything to ones
          for (int i = 0; i < 65536; i++) begin
            mem[i] <= 8'hFF;
          end
        end
        default: begin // No operation
        end
      endcase
    end
  end
endmodule // flc_flash_model
`default_nettype wire

/* tb_top.sv */
// Self-checking bench: APB master, core write port, array model.
// Assumes no APB wait states and a stall per program or erase.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import flc_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [15:0] A_CMD = 16'h3FE0; // Command / status
  localparam logic [15:0] A_PAGE = 16'h3FE4; // Page or guard
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic opt_write_protect = 1'b0;
  logic opt_read_protect = 1'b0;
  logic dbg_access = 1'b0; // Register access from debugger
  logic mdbg = 1'b0; // Memory writes from debugger
  flc_mem_wr_s mem_wr = '0;
  flc_flash_cmd_s flash_cmd;
  logic cpu_stall;
  logic irq_defer;
  logic info_map;
  logic [15:0] rd_addr = 16'h0000;
  logic [7:0] rd_data;
  logic [31:0] rdv; // Last read data
  logic errv; // Last error flag
  logic stl; // Stall seen
  int n_mismatch = 0;
  int comparisons = 0;

  flc_controller u_flc_controller (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dbg_access(dbg_access),
    .opt_write_protect(opt_write_protect), .opt_read_protect(opt_read_protect),
    .mem_wr(mem_wr),
    .flash_cmd(flash_cmd), .cpu_stall(cpu_stall), .irq_defer(irq_defer),
    .info_area_map_enable(info_map));
  flc_flash_model u_flc_flash_model (.pclk(pclk), .flash_cmd(flash_cmd),
    .rd_addr(rd_addr), .rd_data(rd_data));

  // Clock of 40 ns
  initial begin
    forever #20 pclk = ~pclk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string what);
    apb(1'b0, a, 8'h00);
    chk(rdv, {24'h000000, exp}, what);
  endtask

  task automatic peek(input logic [15:0] a, input logic [7:0] exp);
    rd_addr = a;
    #1;
    chk(32'(rd_data), 32'(exp), "cell");
  endtask

  // Wait out a stall, defer must track it
  task automatic wait_idle;
    for (int k = 0; k < 2000 && cpu_stall !== 1'b0; k++) begin
      @(negedge pclk);
      chk(32'(irq_defer), 32'(cpu_stall), "defer");
    end
    chk(32'(cpu_stall), 32'h0, "idle");
  endtask

  // Core or debugger (mdbg) write to program memory, checks whether it stalled
  task automatic mwr(input logic [15:0] a, input logic [7:0] d, input logic exp);
    @(posedge pclk);
    mem_wr <= '{vld: 1'b1, dbg: mdbg, addr: a, data: d};
    @(posedge pclk);
    mem_wr <= '0;
    stl = 1'b0;
    repeat (5) begin
      @(negedge pclk);
      stl = stl | (cpu_stall === 1'b1);
    end
    wait_idle;
    chk(32'(stl), 32'(exp), "stall");
  endtask

  task automatic unl(input logic [7:0] p);
    apb(1'b1, A_CMD, 8'h00);
    apb(1'b1, A_PAGE, p);
    apb(1'b1, A_CMD, 8'h73);
    apb(1'b1, A_CMD, 8'h8C);
    apb(1'b1, A_PAGE, p);
  endtask

  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd_chk(A_CMD, 8'h00, "status");
    rd_chk(A_PAGE, 8'h00, "page");
    apb(1'b1, 16'h0010, 8'h55);
    chk(32'(errv), 32'h1, "unmapped");
    $display("test reset done");
  endtask

  task automatic t_prog;
    apb(1'b1, 16'h3FEC, 8'h01);
    apb(1'b1, A_CMD, 8'h00);
    apb(1'b1, A_PAGE, 8'h03);
    apb(1'b1, A_CMD, 8'h73);
    rd_chk(A_CMD, 8'h01, "key1");
    apb(1'b1, A_CMD, 8'h8C);
    rd_chk(A_CMD, 8'h02, "key2");
    apb(1'b1, A_PAGE, 8'h03);
    rd_chk(A_CMD, 8'h03, "open");
    mwr(16'h0605, 8'h5A, 1'b1);
    mwr(16'h0800, 8'h00, 1'b0);
    mwr(16'h0605, 8'hF0, 1'b1); // Second and last program here
    peek(16'h0605, 8'h50);
    peek(16'h0800, 8'hFF);
    apb(1'b1, A_CMD, 8'h00);
    rd_chk(A_CMD, 8'h00, "relock");
    mwr(16'h0606, 8'h00, 1'b0);
    $display("test prog done");
  endtask

  task automatic t_erase;
    unl(8'h03);
    apb(1'b1, A_CMD, 8'h95);
    rd_chk(A_CMD, 8'h10, "erasing");
    wait_idle;
    rd_chk(A_CMD, 8'h00, "post erase");
    peek(16'h0605, 8'hFF);
    unl(8'h03);
    mwr(16'h0605, 8'h00, 1'b1);
    $display("test erase done");
  endtask

  task automatic t_cmds;
    unl(8'h02);
    apb(1'b1, A_CMD, 8'h63);
    rd_chk(A_CMD, 8'h00, "mass");
    apb(1'b1, A_CMD, 8'h00);
    apb(1'b1, A_CMD, 8'h73);
    rd_chk(A_CMD, 8'h00, "early key");
    apb(1'b1, A_PAGE, 8'h81);
    rd_chk(A_PAGE, 8'h81, "page rw");
    chk(32'(info_map), 32'h1, "info");
    apb(1'b1, A_PAGE, 8'h00);
    $display("test cmds done");
  endtask

  task automatic t_guard;
    apb(1'b1, A_CMD, 8'h00);
    apb(1'b1, A_CMD, 8'h5E);
    rd_chk(A_CMD, 8'h04, "guard sel");
    apb(1'b1, A_PAGE, 8'h01);
    apb(1'b1, A_PAGE, 8'h00);
    rd_chk(A_PAGE, 8'h01, "set only");
    apb(1'b1, A_CMD, 8'h00);
    rd_chk(A_PAGE, 8'h00, "page back");
    unl(8'h03);
    mwr(16'h0606, 8'h00, 1'b0);
    apb(1'b1, A_CMD, 8'h95);
    wait_idle;
    peek(16'h0605, 8'h00);
    opt_write_protect <= 1'b1;
    do_reset;
    rd_chk(A_CMD, 8'h00, "second reset");
    unl(8'h03);
    mwr(16'h0606, 8'h00, 1'b0);
    $display("test guard done");
  endtask

  // Debugger path: guards and write option ignored, mass erase, read protect
  task automatic t_dbg;
    @(posedge pclk);
    dbg_access <= 1'b1;
    mdbg <= 1'b1;
    apb(1'b1, 16'h3FEC, 8'h01);
    apb(1'b1, A_CMD, 8'h00);
    apb(1'b1, A_CMD, 8'h5E);
    apb(1'b1, A_PAGE, 8'h03);
    apb(1'b1, A_PAGE, 8'h01);
    rd_chk(A_PAGE, 8'h01, "dbg guard");
    apb(1'b1, A_CMD, 8'h00);
    apb(1'b1, A_PAGE, 8'h03);
    apb(1'b1, A_CMD, 8'h73);
    apb(1'b1, A_CMD, 8'h8C);
    rd_chk(A_CMD, 8'h03, "dbg open");
    apb(1'b1, A_PAGE, 8'h05);
    rd_chk(A_CMD, 8'h03, "dbg page");
    mwr(16'h0010, 8'h0F, 1'b1);
    peek(16'h0010, 8'h0F);
    apb(1'b1, A_CMD, 8'h63);
    rd_chk(A_CMD, 8'h20, "dbg mass");
    wait_idle;
    peek(16'h0010, 8'hFF);
    opt_read_protect <= 1'b1;
    unl(8'h03);
    mwr(16'h0010, 8'h00, 1'b0);
    peek(16'h0010, 8'hFF);
    $display("test dbg done");
  endtask

  // Main sequence
  initial begin
    do_reset;
    t_reset;
    t_prog;
    t_erase;
    t_cmds;
    t_guard;
    t_dbg;
    tally_and_finish;
  end

  // Watchdog well past the expected run
  initial begin
    #2000000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule // tb_top
`default_nettype wire
